// file: acc_map.svh
/*
 Register offsets, field positions and reset values for the channel
 configuration and calibration bank. Assumes a 16-bit register word and
 an 8-bit register address from the serial host port decoder.
*/
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ACC_ADDR_CHANNEL1_CONFIGURATION 8'h0E
`define ACC_ADDR_CH1_OFS_HI 8'h0F
`define ACC_ADDR_CH1_OFS_LO 8'h10
`define ACC_ADDR_CH1_GAIN_HI 8'h11
`define ACC_ADDR_CH1_GAIN_LO 8'h12
`define ACC_ADDR_CHANNEL2_CONFIGURATION 8'h13
`define ACC_ADDR_CH2_OFS_HI 8'h14
`define ACC_ADDR_CH2_OFS_LO 8'h15
`define ACC_ADDR_CH2_GAIN_HI 8'h16
`define ACC_ADDR_CH2_GAIN_LO 8'h17

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ACC_PHASE_HI 15
`define ACC_PHASE_LO 6
`define ACC_TEMP_SRC_BIT 5
`define ACC_TEMP_EN_BIT 4
`define ACC_TEMP_INV_BIT 2
`define ACC_MUX_HI 1
`define ACC_MUX_LO 0
`define ACC_LOWER_HI 15
`define ACC_LOWER_LO 8

// ----------------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------------
`define ACC_RST_CFG 16'h0000
`define ACC_RST_OFS 16'h0000
`define ACC_RST_GAIN_HI 16'h8000
`define ACC_RST_GAIN_LO 16'h0000
`define ACC_MASK_CHANNEL1_CONFIGURATION 16'hFFC3
`define ACC_MASK_CHANNEL2_CONFIGURATION 16'hFFF7
`define ACC_MASK_LOWER 16'hFF00
`define ACC_MASK_FULL 16'hFFFF

`endif

// file: acc_pkg.sv
/*
 Types shared by the channel configuration and calibration bank.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package acc_pkg;
   typedef enum logic [1:0] {
      ACC_IN_NORMAL,
      ACC_IN_SHORTED,
      ACC_IN_DC_DIAG,
      ACC_IN_AC_DIAG
   } acc_input_sel_t;

   typedef logic [15:0] acc_word_t;
   typedef logic signed [9:0] acc_phase_t;
   typedef logic [23:0] acc_cal_t;
endpackage

// file: acc_in_decode.sv
/*
 Decodes one channel's two-bit input select into one-hot route enables.
 Assumes the select comes from a register on the same clock.
*/
`timescale 1ns/1ps
module acc_in_decode (
   input wire acc_pkg::acc_input_sel_t sel_i,
   output logic route_normal_o,
   output logic route_short_o,
   output logic route_dc_diag_o,
   output logic route_ac_diag_o
);
   import acc_pkg::*;

   always_comb begin
      route_normal_o = 1'b0;
      route_short_o = 1'b0;
      route_dc_diag_o = 1'b0;
      route_ac_diag_o = 1'b0;
      case (sel_i)
         ACC_IN_NORMAL: route_normal_o = 1'b1;
         ACC_IN_SHORTED: route_short_o = 1'b1;
         ACC_IN_DC_DIAG: route_dc_diag_o = 1'b1;
         ACC_IN_AC_DIAG: route_ac_diag_o = 1'b1;
         default: route_normal_o = 1'b1;
      endcase
   end
endmodule

// file: acc_correct.sv
/*
 Offset then gain correction of one channel's 24-bit conversion result.
 Gain is unsigned with 1.0 at 800000h. One register stage of latency.
*/
`timescale 1ns/1ps
module acc_correct (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic sample_valid_i,
   input wire logic [23:0] sample_i,
   input wire acc_pkg::acc_cal_t offset_i,
   input wire acc_pkg::acc_cal_t gain_i,
   output logic result_valid_o,
   output logic [23:0] result_o
);
   import acc_pkg::*;

   logic signed [24:0] sum;
   logic signed [49:0] prod;
   logic signed [25:0] scaled;
   logic [23:0] next_result;

   // Clamp to the 24-bit range rather than wrap on overflow
   always_comb begin
      sum = $signed({sample_i[23], sample_i}) +
            $signed({offset_i[23], offset_i});
      prod = sum * $signed({1'b0, gain_i});
      scaled = prod[48:23];
      if (scaled > 26'sh07FFFFF) begin
         next_result = 24'h7FFFFF;
      end else if (scaled < -26'sh0800000) begin
         next_result = 24'h800000;
      end else begin
         next_result = scaled[23:0];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         result_valid_o <= 1'b0;
         result_o <= 24'h000000;
      end else begin
         result_valid_o <= sample_valid_i;
         if (sample_valid_i) begin
            result_o <= next_result;
         end
      end
   end
endmodule

// file: acc_bank.sv
/*
 Configuration and calibration register bank for channels 1 and 2.
 Assumes the serial host port decoder on mclk_i presents one-cycle write
 and read strobes with an 8-bit address and 16-bit data; the read data
 is registered and valid the cycle after the read strobe.
*/
`timescale 1ns/1ps
`include "acc_map.svh"

// Summary of operation
// - Each config register holds a signed 10-bit phase delay in 15:6.
// - Channel 1 select 1:0: normal, shorted, DC diagnostic, AC diagnostic.
// - Channel 2 select uses the same four-way encoding.
// - Channel 1 offset bits 23:8 live in the whole upper register.
// - Offset bits 7:0 sit in lower 15:8; lower 7:0 read zero.
// - Channel 1 gain is unsigned 24-bit, bits 23:8 in upper register.
// - Gain bits 7:0 sit in lower 15:8; lower 7:0 read zero.
// - Gain upper at 11h resets 8000h; gain lower resets zero.
// - Channel 2 config bit 5 picks internal or external temp sensor.
// - Channel 2 config bit 4 enables temperature measurement.
// - Channel 2 config bit 2 reverses temp sensor input polarity.
// - Channel 1 config at 0Eh resets to 0000h.
// - Channel 2 config at 13h resets to 0000h.
// - Offset upper at 0Fh, lower at 10h, both reset 0000h.
// - Channel 1 gain lower at 12h resets to 0000h.
// - Channel 2 offset and gain follow channel 1 layout at 14h-17h.
module acc_bank (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire acc_pkg::acc_word_t reg_wdata_i,
   output acc_pkg::acc_word_t reg_rdata_o,
   output logic reg_hit_o,
   input wire logic ch1_sample_valid_i,
   input wire logic [23:0] ch1_sample_i,
   input wire logic ch2_sample_valid_i,
   input wire logic [23:0] ch2_sample_i,
   output logic ch1_result_valid_o,
   output logic [23:0] ch1_result_o,
   output logic ch2_result_valid_o,
   output logic [23:0] ch2_result_o,
   output acc_pkg::acc_phase_t ch1_phase_delay_o,
   output acc_pkg::acc_phase_t ch2_phase_delay_o,
   output logic ch1_route_normal_o,
   output logic ch1_route_short_o,
   output logic ch1_route_dc_diag_o,
   output logic ch1_route_ac_diag_o,
   output logic ch2_route_normal_o,
   output logic ch2_route_short_o,
   output logic ch2_route_dc_diag_o,
   output logic ch2_route_ac_diag_o,
   output logic temp_source_select_o,
   output logic temp_measure_enable_o,
   output logic temp_input_invert_o
);
   import acc_pkg::*;

   // -------------------------------------------------------------------
   // Register storage
   // -------------------------------------------------------------------
   acc_word_t channel1_configuration;
   acc_word_t ch1_ofs_hi;
   acc_word_t ch1_ofs_lo;
   acc_word_t ch1_gain_hi;
   acc_word_t ch1_gain_lo;
   acc_word_t channel2_configuration;
   acc_word_t ch2_ofs_hi;
   acc_word_t ch2_ofs_lo;
   acc_word_t ch2_gain_hi;
   acc_word_t ch2_gain_lo;
   acc_word_t next_rdata;
   logic next_hit;

   function automatic acc_word_t wr_masked(input acc_word_t data,
                                          input acc_word_t mask);
      wr_masked = data & mask;
   endfunction

   function automatic logic wr_at(input logic wr, input logic [7:0] addr,
                                  input logic [7:0] target);
      wr_at = wr && (addr == target);
   endfunction

   // -------------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------------
   // Reserved bits are masked at write so storage never holds them
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         channel1_configuration <= `ACC_RST_CFG;
         channel2_configuration <= `ACC_RST_CFG;
      end else begin
         if (wr_at(reg_wr_i, reg_addr_i, `ACC_ADDR_CHANNEL1_CONFIGURATION)) begin
            channel1_configuration <= wr_masked(reg_wdata_i, `ACC_MASK_CHANNEL1_CONFIGURATION);
         end
         if (wr_at(reg_wr_i, reg_addr_i, `ACC_ADDR_CHANNEL2_CONFIGURATION)) begin
            channel2_configuration <= wr_masked(reg_wdata_i, `ACC_MASK_CHANNEL2_CONFIGURATION);
         end
      end
   end

   // -------------------------------------------------------------------
   // Offset calibration registers
   // -------------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ch1_ofs_hi <= `ACC_RST_OFS;
         ch1_ofs_lo <= `ACC_RST_OFS;
         ch2_ofs_hi <= `ACC_RST_OFS;
         ch2_ofs_lo <= `ACC_RST_OFS;
      end else begin
         if (wr_at(reg_wr_i, reg_addr_i, `ACC_ADDR_CH1_OFS_HI)) begin
            ch1_ofs_hi <= reg_wdata_i;
         end
         if (wr_at(reg_wr_i, reg_addr_i, `ACC_ADDR_CH1_OFS_LO)) begin
            ch1_ofs_lo <= wr_masked(reg_wdata_i, `ACC_MASK_LOWER);
         end
         if (wr_at(reg_wr_i, reg_addr_i, `ACC_ADDR_CH2_OFS_HI)) begin
            ch2_ofs_hi <= reg_wdata_i;
         end
         if (wr_at(reg_wr_i, reg_addr_i, `ACC_ADDR_CH2_OFS_LO)) begin
            ch2_ofs_lo <= wr_masked(reg_wdata_i, `ACC_MASK_LOWER);
         end
      end
   end

   // -------------------------------------------------------------------
   // Gain calibration registers
   // -------------------------------------------------------------------
   // Upper reset of 8000h puts the gain word at exactly 1.0
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ch1_gain_hi <= `ACC_RST_GAIN_HI;
         ch1_gain_lo <= `ACC_RST_GAIN_LO;
         ch2_gain_hi <= `ACC_RST_GAIN_HI;
         ch2_gain_lo <= `ACC_RST_GAIN_LO;
      end else begin
         if (wr_at(reg_wr_i, reg_addr_i, `ACC_ADDR_CH1_GAIN_HI)) begin
            ch1_gain_hi <= reg_wdata_i;
         end
         if (wr_at(reg_wr_i, reg_addr_i, `ACC_ADDR_CH1_GAIN_LO)) begin
            ch1_gain_lo <= wr_masked(reg_wdata_i, `ACC_MASK_LOWER);
         end
         if (wr_at(reg_wr_i, reg_addr_i, `ACC_ADDR_CH2_GAIN_HI)) begin
            ch2_gain_hi <= reg_wdata_i;
         end
         if (wr_at(reg_wr_i, reg_addr_i, `ACC_ADDR_CH2_GAIN_LO)) begin
            ch2_gain_lo <= wr_masked(reg_wdata_i, `ACC_MASK_LOWER);
         end
      end
   end

   // -------------------------------------------------------------------
   // Read-back
   // -------------------------------------------------------------------
   // Unmapped addresses read zero with reg_hit_o low
   always_comb begin
      next_rdata = 16'h0000;
      next_hit = 1'b1;
      case (reg_addr_i)
         `ACC_ADDR_CHANNEL1_CONFIGURATION: next_rdata = channel1_configuration;
         `ACC_ADDR_CH1_OFS_HI: next_rdata = ch1_ofs_hi;
         `ACC_ADDR_CH1_OFS_LO: next_rdata = ch1_ofs_lo;
         `ACC_ADDR_CH1_GAIN_HI: next_rdata = ch1_gain_hi;
         `ACC_ADDR_CH1_GAIN_LO: next_rdata = ch1_gain_lo;
         `ACC_ADDR_CHANNEL2_CONFIGURATION: next_rdata = channel2_configuration;
         `ACC_ADDR_CH2_OFS_HI: next_rdata = ch2_ofs_hi;
         `ACC_ADDR_CH2_OFS_LO: next_rdata = ch2_ofs_lo;
         `ACC_ADDR_CH2_GAIN_HI: next_rdata = ch2_gain_hi;
         `ACC_ADDR_CH2_GAIN_LO: next_rdata = ch2_gain_lo;
         default: next_hit = 1'b0;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 16'h0000;
         reg_hit_o <= 1'b0;
      end else if (reg_rd_i) begin
         reg_rdata_o <= next_rdata;
         reg_hit_o <= next_hit;
      end
   end

   // -------------------------------------------------------------------
   // Field outputs
   // -------------------------------------------------------------------
   assign ch1_phase_delay_o = channel1_configuration[`ACC_PHASE_HI:`ACC_PHASE_LO];
   assign ch2_phase_delay_o = channel2_configuration[`ACC_PHASE_HI:`ACC_PHASE_LO];
   assign temp_source_select_o = channel2_configuration[`ACC_TEMP_SRC_BIT];
   assign temp_measure_enable_o = channel2_configuration[`ACC_TEMP_EN_BIT];
   assign temp_input_invert_o = channel2_configuration[`ACC_TEMP_INV_BIT];

   // Input selection routes, one-hot
   acc_in_decode u_ch1_mux (
      .sel_i(acc_input_sel_t'(channel1_configuration[`ACC_MUX_HI:`ACC_MUX_LO])),
      .route_normal_o(ch1_route_normal_o),
      .route_short_o(ch1_route_short_o),
      .route_dc_diag_o(ch1_route_dc_diag_o),
      .route_ac_diag_o(ch1_route_ac_diag_o)
   );

   acc_in_decode u_ch2_mux (
      .sel_i(acc_input_sel_t'(channel2_configuration[`ACC_MUX_HI:`ACC_MUX_LO])),
      .route_normal_o(ch2_route_normal_o),
      .route_short_o(ch2_route_short_o),
      .route_dc_diag_o(ch2_route_dc_diag_o),
      .route_ac_diag_o(ch2_route_ac_diag_o)
   );

   // -------------------------------------------------------------------
   // Result correction
   // -------------------------------------------------------------------
   acc_correct u_ch1_corr (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .sample_valid_i(ch1_sample_valid_i),
      .sample_i(ch1_sample_i),
      .offset_i({ch1_ofs_hi, ch1_ofs_lo[15:8]}),
      .gain_i({ch1_gain_hi, ch1_gain_lo[15:8]}),
      .result_valid_o(ch1_result_valid_o),
      .result_o(ch1_result_o)
   );

   acc_correct u_ch2_corr (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .sample_valid_i(ch2_sample_valid_i),
      .sample_i(ch2_sample_i),
      .offset_i({ch2_ofs_hi, ch2_ofs_lo[15:8]}),
      .gain_i({ch2_gain_hi, ch2_gain_lo[15:8]}),
      .result_valid_o(ch2_result_valid_o),
      .result_o(ch2_result_o)
   );

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   sequence wr_cfg1_s;
      reg_wr_i && reg_addr_i == 8'h0E;
   endsequence

   sequence rd_back_s(logic [7:0] a);
      reg_rd_i && !reg_wr_i && reg_addr_i == a;
   endsequence

   channel1_configuration_rsvd_a:
      assert property (@(posedge mclk_i) disable iff (!rst_n_i)
         channel1_configuration[5:2] == 4'h0 && channel2_configuration[3] == 1'b0)
      else $error("reserved config bits not zero");

   cfg1_wr_rd_a:
      assert property (@(posedge mclk_i) disable iff (!rst_n_i)
         wr_cfg1_s ##1 !reg_wr_i ##1 rd_back_s(8'h0E) |=>
            reg_rdata_o == ($past(reg_wdata_i, 3) & 16'hFFC3))
      else $error("channel 1 config read-back mismatch");

   cfg1_write_a:
      assert property (@(posedge mclk_i) disable iff (!rst_n_i)
         wr_cfg1_s |=> channel1_configuration == ($past(reg_wdata_i) & 16'hFFC3))
      else $error("channel 1 config write did not land");

   lower_rsvd_a:
      assert property (@(posedge mclk_i) disable iff (!rst_n_i)
         reg_rd_i && (reg_addr_i == 8'h10 || reg_addr_i == 8'h12) |=>
            reg_rdata_o[7:0] == 8'h00 && reg_hit_o)
      else $error("lower register low byte not zero");

   gain_reset_a:
      assert property (@(posedge mclk_i)
         $rose(rst_n_i) |-> ch1_gain_hi == 16'h8000 &&
            ch1_gain_lo == 16'h0000 && ch2_gain_hi == 16'h8000)
      else $error("gain reset value wrong");

   cfg_reset_a:
      assert property (@(posedge mclk_i)
         $rose(rst_n_i) |-> channel1_configuration == 16'h0000 && channel2_configuration == 16'h0000 &&
            ch1_ofs_hi == 16'h0000 && ch1_ofs_lo == 16'h0000)
      else $error("config or offset reset value wrong");

   temp_bits_a:
      assert property (@(posedge mclk_i) disable iff (!rst_n_i)
         reg_wr_i && reg_addr_i == 8'h13 |=>
            temp_measure_enable_o == $past(reg_wdata_i[4]) &&
            temp_source_select_o == $past(reg_wdata_i[5]) &&
            temp_input_invert_o == $past(reg_wdata_i[2]))
      else $error("temperature controls did not follow write");

   mux_route_a:
      assert property (@(posedge mclk_i) disable iff (!rst_n_i)
         channel1_configuration[1:0] == 2'h1 |-> ch1_route_short_o && !ch1_route_normal_o)
      else $error("channel 1 shorted route not selected");

   unmapped_a:
      assert property (@(posedge mclk_i) disable iff (!rst_n_i)
         reg_rd_i && (reg_addr_i < 8'h0E || reg_addr_i > 8'h17) |=>
            !reg_hit_o && reg_rdata_o == 16'h0000)
      else $error("unmapped read answered");

   unity_gain_a:
      assert property (@(posedge mclk_i) disable iff (!rst_n_i)
         ch1_sample_valid_i && ch1_gain_hi == 16'h8000 &&
         ch1_gain_lo[15:8] == 8'h00 && ch1_ofs_hi == 16'h0000 &&
         ch1_ofs_lo[15:8] == 8'h00 |=> ch1_result_valid_o &&
            ch1_result_o == $past(ch1_sample_i))
      else $error("unity correction altered sample");
endmodule

// file: acc_host_model.sv
/*
 Host-side model of the serial port decoder: one-cycle write and read
 strobes with address and data. Assumes the bank shares mclk_i.
*/
`timescale 1ns/1ps
module acc_host_model (
   input wire logic mclk_i,
   input wire acc_pkg::acc_word_t reg_rdata_i,
   input wire logic reg_hit_i,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_addr_o,
   output acc_pkg::acc_word_t reg_wdata_o
);
   import acc_pkg::*;
   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 16'h0000;
   end
   // Released lines show the inverse, so a stale value never matches
   task automatic write_reg(input logic [7:0] addr, input acc_word_t data);
      @(posedge mclk_i);
      reg_wr_o <= 1'b1;
      reg_addr_o <= addr;
      reg_wdata_o <= data;
      @(posedge mclk_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~addr;
      reg_wdata_o <= ~data;
   endtask
   task automatic read_reg(input logic [7:0] addr, output acc_word_t data,
                           output logic hit);
      @(posedge mclk_i);
      reg_rd_o <= 1'b1;
      reg_addr_o <= addr;
      @(posedge mclk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~addr;
      #1;
      data = reg_rdata_i;
      hit = reg_hit_i;
   endtask
endmodule

// file: tb.sv
/*
 Self-checking bench for the channel configuration and calibration bank.
 Assumes the host model file and the design files are compiled first.
*/
`timescale 1ns/1ps
module tb;
   import acc_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic reg_wr, reg_rd, reg_hit, v1, v2, rv1, rv2;
   logic [7:0] reg_addr;
   acc_word_t wdata, rdata;
   logic [23:0] s1 = 24'h000000;
   logic [23:0] s2 = 24'h000000;
   logic [23:0] r1, r2;
   acc_phase_t ph1, ph2;
   wire [3:0] rt1, rt2;
   wire [2:0] tmp;
   int n_mismatch = 0;
   int checks = 0;
   logic [9:0] ph [4] = '{10'h200, 10'h1FF, 10'h3FF, 10'h001};
   initial begin
      v1 = 1'b0;
      v2 = 1'b0;
   end
   always #2.5 mclk_i = ~mclk_i;

   acc_host_model acc_host_model_inst (.mclk_i(mclk_i),
      .reg_rdata_i(rdata), .reg_hit_i(reg_hit), .reg_wr_o(reg_wr),
      .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(wdata));
   acc_bank acc_bank_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_hit_o(reg_hit),
      .ch1_sample_valid_i(v1), .ch1_sample_i(s1),
      .ch2_sample_valid_i(v2), .ch2_sample_i(s2),
      .ch1_result_valid_o(rv1), .ch1_result_o(r1),
      .ch2_result_valid_o(rv2), .ch2_result_o(r2),
      .ch1_phase_delay_o(ph1), .ch2_phase_delay_o(ph2),
      .ch1_route_normal_o(rt1[3]), .ch1_route_short_o(rt1[2]),
      .ch1_route_dc_diag_o(rt1[1]), .ch1_route_ac_diag_o(rt1[0]),
      .ch2_route_normal_o(rt2[3]), .ch2_route_short_o(rt2[2]),
      .ch2_route_dc_diag_o(rt2[1]), .ch2_route_ac_diag_o(rt2[0]),
      .temp_source_select_o(tmp[2]), .temp_measure_enable_o(tmp[1]),
      .temp_input_invert_o(tmp[0]));

   // ------------------------------------------------------------------
   // Shared helpers
   // ------------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input acc_word_t d);
      acc_host_model_inst.write_reg(a, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input acc_word_t exp);
      acc_word_t d;
      logic h;
      acc_host_model_inst.read_reg(a, d, h);
      check(32'(d), 32'(exp));
      check(32'(h), 32'h1);
   endtask
   // Valid is a one-cycle pulse; result must hold after it drops
   task automatic sample_chk(input logic [23:0] a, input logic [23:0] b,
                             input logic [23:0] ea, input logic [23:0] eb);
      @(posedge mclk_i);
      v1 <= 1'b1;
      v2 <= 1'b1;
      s1 <= a;
      s2 <= b;
      @(posedge mclk_i);
      v1 <= 1'b0;
      v2 <= 1'b0;
      s1 <= ~a;
      s2 <= ~b;
      #1;
      check(32'({rv1, rv2}), 32'h3);
      check(32'(r1), 32'(ea));
      check(32'(r2), 32'(eb));
      @(posedge mclk_i);
      #1;
      check(32'({rv1, rv2}), 32'h0);
      check(32'(r1), 32'(ea));
      check(32'(r2), 32'(eb));
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_reset;
      rd_chk(8'h0E, 16'h0000);
      rd_chk(8'h0F, 16'h0000);
      rd_chk(8'h10, 16'h0000);
      rd_chk(8'h11, 16'h8000);
      rd_chk(8'h12, 16'h0000);
      rd_chk(8'h13, 16'h0000);
      rd_chk(8'h14, 16'h0000);
      rd_chk(8'h15, 16'h0000);
      rd_chk(8'h16, 16'h8000);
      rd_chk(8'h17, 16'h0000);
      check(32'({rt1, rt2, tmp, ph1, ph2}), 32'({8'h88, 3'b000, 20'h0}));
      sample_chk(24'h000100, 24'hFFFF00, 24'h000100, 24'hFFFF00);
   endtask
   task automatic t_channel1_configuration;
      logic [1:0] m;
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         wr(8'h0E, {ph[i], 4'hF, m});
         rd_chk(8'h0E, {ph[i], 4'h0, m});
         check(32'(ph1), 32'($signed(ph[i])));
         check(32'(rt1), 32'(4'b1000 >> m));
      end
   endtask
   // Temp bits walk 000,011,110,001 so each goes both ways
   task automatic t_channel2_configuration;
      logic [1:0] m;
      logic [2:0] t;
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         t = 3'(i * 3);
         wr(8'h13, {ph[3 - i], t[2], t[1], 1'b1, t[0], m});
         rd_chk(8'h13, {ph[3 - i], t[2], t[1], 1'b0, t[0], m});
         check(32'(tmp), 32'(t));
         check(32'(rt2), 32'(4'b1000 >> m));
         check(32'(ph2), 32'($signed(ph[3 - i])));
      end
   endtask
   task automatic t_cal;
      logic [7:0] a;
      for (int i = 0; i < 8; i++) begin
         a = (i < 4) ? 8'(8'h0F + i) : 8'(8'h10 + i);
         wr(a, 16'hFFFF);
         rd_chk(a, (i % 2 == 0) ? 16'hFFFF : 16'hFF00);
      end
   endtask
   task automatic t_corr;
      wr(8'h0F, 16'h0000);
      wr(8'h10, 16'h1000);
      wr(8'h11, 16'h4000);
      wr(8'h12, 16'h0000);
      sample_chk(24'h000100, 24'h7FFFFF, 24'h000088, 24'h7FFFFF);
      sample_chk(24'h000000, 24'h800000, 24'h000008, 24'h800000);
   endtask
   task automatic t_unmapped;
      acc_word_t d;
      logic h;
      wr(8'h0D, 16'hFFFF);
      wr(8'h18, 16'hFFFF);
      acc_host_model_inst.read_reg(8'h0D, d, h);
      check(32'({h, d}), 32'h0);
      acc_host_model_inst.read_reg(8'h18, d, h);
      check(32'({h, d}), 32'h0);
      rd_chk(8'h0E, 16'h0043);
      rd_chk(8'h13, 16'h8007);
   endtask
   // Reset mid-run, after registers and results have moved off reset
   task automatic t_mid_reset;
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      #1;
      check(32'({rv1, rv2, reg_hit}), 32'h0);
      check(32'(r1), 32'h0);
      check(32'(r2), 32'h0);
      check(32'(rdata), 32'h0);
      t_reset;
   endtask

   // ------------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------------
   task automatic complete_run;
      if (n_mismatch == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_reset;
      t_channel1_configuration;
      t_channel2_configuration;
      t_cal;
      t_corr;
      t_unmapped;
      t_mid_reset;
      complete_run;
   end
   // Whole run needs about 150 cycles; this leaves wide margin
   initial begin
      repeat (5000) @(posedge mclk_i);
      n_mismatch++;
      complete_run;
   end
endmodule
